// [src/trap_and_interrupt_control.sv]
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module trap_and_interrupt_control
   import trap_ctrl_pkg::*;
#(
   parameter int N_EXC = 8
) (
   input wire logic pclk, // core clock, 100 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped
   output logic irq, // level, unmasked status set
   input wire logic nonmaskable_request, // async level pin
   input wire logic [3:0] request_level_input, // async encoded level
   input wire logic pipe_advance, // pipeline moves this cycle
   input wire logic [N_EXC-1:0] exc_req, // final-stage conditions
   input wire logic [31:0] c_pc, // pc of final-stage instruction
   input wire logic [31:0] c_next_pc, // pc of next unexecuted one
   output logic d_inject, // pulse, interrupt enters decode
   output logic trap_busy, // stall while a trap is built
   output logic frame_push_valid, // frame word offered
   output logic [31:0] frame_push_data, // frame word
   input wire logic frame_push_ready, // stack took the word
   output logic table_read_req, // trap table read
   output logic [31:0] table_read_addr, // handler vector address
   input wire logic table_read_ack, // table data valid
   input wire logic [31:0] table_read_data, // handler location
   output logic branch_valid, // pulse, jump to handler
   output logic [31:0] branch_target, // handler first instruction
   output logic privileged // current mode
);
   localparam int NR = N_EXC + 1;
   localparam int IW = $clog2(NR + 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   trap_state_t state;
   logic ie, took_nmi, nmi_armed, nmi_sync;
   logic [3:0] processor_priority_threshold, irl_sync;
   logic [31:0] tbase, saved_pc, saved_psr, target;
   logic [ST_W-1:0] status, mask;
   logic d_v, e_v, c_v;
   logic d_nmi, e_nmi, c_nmi;
   logic [7:0] last_kind, d_kind, e_kind, c_kind;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   level_sync3 #(.W(1)) u_nmi_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(nonmaskable_request),
      .stable_out(nmi_sync)
   );

   // level is not latched, so the source keeps it up
   level_sync3 #(.W(4)) u_irl_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(request_level_input),
      .stable_out(irl_sync)
   );

   // ----------------------------------------------------------------
   // acceptance and decode-stage injection
   // ----------------------------------------------------------------
   wire in_flight = d_v | e_v | c_v;
   wire idle = (state == s_idle);
   // no mode term: user and privileged both accept
   wire nmi_ok = ie & nmi_sync & nmi_armed;
   wire irq_ok = ie & (irl_sync > processor_priority_threshold);
   // a same-cycle exception flushes the slot and would strand the block on nmi
   wire inject_ok = (nmi_ok | irq_ok) & ~in_flight & idle & pipe_advance & ~(|exc_req);
   wire inject_nmi = inject_ok & nmi_ok;
   wire [7:0] inject_kind = nmi_ok ? KIND_NMI : KIND_IRQ_BASE + {4'h0, irl_sync};
   assign d_inject = inject_ok;

   // ----------------------------------------------------------------
   // final-stage resolution
   // ----------------------------------------------------------------
   wire c_int_ok = c_v & ie;
   wire [NR-1:0] cond = {c_int_ok, exc_req};
   wire any_cond;
   wire [IW-1:0] win;

   trap_prio #(.N(NR), .IW(IW)) u_prio (
      .pclk(pclk),
      .presetn(presetn),
      .req(cond),
      .any(any_cond),
      .idx(win)
   );

   // new conditions wait while busy, so arrival order holds
   wire take = idle & any_cond;
   wire win_int = (win == IW'(N_EXC));
   wire [7:0] win_kind = win_int ? c_kind : KIND_EXC_BASE + 8'(win);
   wire slot_adv = pipe_advance & idle & ~take;
   // an interrupt dropped or flushed without entry re-arms the line
   wire nmi_lost = (take & ~(win_int & c_nmi) & (d_nmi | e_nmi | c_nmi))
                   | (idle & c_v & ~ie & c_nmi);
   wire [31:0] cur_psr = (32'(ie) << CTRL_IE_BIT) | (32'(processor_priority_threshold) << CTRL_PIL_LSB)
                         | (32'(privileged) << CTRL_PRIV_BIT);

   // interrupt marker rides decode, execute, final stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {d_v, e_v, c_v} <= 3'h0;
         {d_nmi, e_nmi, c_nmi} <= 3'h0;
         {d_kind, e_kind, c_kind} <= 24'h0;
      end
      else if (take)
      begin
         {d_v, e_v, c_v} <= 3'h0; // flushed by the trap
      end
      else if (idle & c_v & ~ie)
      begin
         c_v <= 1'b0; // enable dropped in flight
      end
      else if (slot_adv)
      begin
         {d_v, d_nmi, d_kind} <= {inject_ok, inject_nmi, inject_kind};
         {e_v, e_nmi, e_kind} <= {d_v, d_nmi, d_kind};
         {c_v, c_nmi, c_kind} <= {e_v, e_nmi, e_kind};
      end
   end

   // nonmaskable line blocked from acceptance to handler entry
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         nmi_armed <= 1'b1;
      else if (inject_nmi)
         nmi_armed <= 1'b0;
      else if ((state == s_branch & took_nmi) | nmi_lost)
         nmi_armed <= 1'b1;
   end

   // ----------------------------------------------------------------
   // trap sequencer
   // ----------------------------------------------------------------
   // no depth counter: each trap stacks its own frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= s_idle;
         saved_pc <= 32'h0;
         saved_psr <= 32'h0;
         last_kind <= 8'h0;
         took_nmi <= 1'b0;
         target <= 32'h0;
      end
      else
      begin
         case (state)
            s_idle:
               if (take)
               begin
                  state <= s_push_pc;
                  saved_pc <= win_int ? c_next_pc : c_pc;
                  saved_psr <= cur_psr;
                  last_kind <= win_kind;
                  took_nmi <= win_int & c_nmi;
               end
            s_push_pc:
               if (frame_push_ready)
                  state <= s_push_psr;
            s_push_psr:
               if (frame_push_ready)
                  state <= s_enter_priv;
            s_enter_priv:
               state <= s_read_table;
            s_read_table:
               if (table_read_ack)
               begin
                  target <= table_read_data;
                  state <= s_branch;
               end
            s_branch:
               state <= s_idle;
            default:
               state <= s_idle;
         endcase
      end
   end

   assign trap_busy = ~idle;
   assign frame_push_valid = (state == s_push_pc) | (state == s_push_psr);
   assign frame_push_data = (state == s_push_psr) ? saved_psr : saved_pc;
   assign table_read_req = (state == s_read_table);
   assign table_read_addr = vector_of(tbase, last_kind);
   assign branch_valid = (state == s_branch);
   assign branch_target = target;

   // ----------------------------------------------------------------
   // apb slave, one wait-free access, read data set up in setup phase
   // ----------------------------------------------------------------
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire hit = (paddr == ADDR_CTRL) | (paddr == ADDR_TBASE) | (paddr == ADDR_STATUS)
              | (paddr == ADDR_MASK) | (paddr == ADDR_LAST) | (paddr == ADDR_SAVED_PC);
   wire wr_ctrl = access & pwrite & (paddr == ADDR_CTRL);
   wire wr_tbase = access & pwrite & (paddr == ADDR_TBASE);
   wire wr_mask = access & pwrite & (paddr == ADDR_MASK);
   wire rd_status = access & ~pwrite & (paddr == ADDR_STATUS);
   wire [ST_W-1:0] events = {take & win_int & ~c_nmi, take & win_int & c_nmi, take};
   wire [31:0] rd_mux = (paddr == ADDR_CTRL) ? cur_psr :
                        (paddr == ADDR_TBASE) ? tbase :
                        (paddr == ADDR_STATUS) ? 32'(status) :
                        (paddr == ADDR_MASK) ? 32'(mask) :
                        (paddr == ADDR_LAST) ? 32'(last_kind) :
                        (paddr == ADDR_SAVED_PC) ? saved_pc : 32'h0;
   // clear only the bits the reader saw, so later events survive
   wire [ST_W-1:0] next_status = (status & ~(rd_status ? prdata[ST_W-1:0] : '0)) | events;

   assign pready = 1'b1;
   assign pslverr = access & ~hit;
   assign irq = |(status & mask);

   // register file updates
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
         tbase <= RST_TBASE;
         mask <= RST_MASK;
         status <= '0;
      end
      else
      begin
         if (setup & ~pwrite)
            prdata <= rd_mux;
         if (wr_tbase)
            tbase <= pwdata;
         if (wr_mask)
            mask <= pwdata[ST_W-1:0];
         status <= next_status;
      end
   end

   // processor state word: trap clear beats a software set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ie <= RST_IE;
         processor_priority_threshold <= RST_PIL;
         privileged <= RST_PRIV;
      end
      else
      begin
         if (take)
            ie <= 1'b0;
         else if (wr_ctrl)
            ie <= pwdata[CTRL_IE_BIT];
         if (wr_ctrl)
            processor_priority_threshold <= pwdata[CTRL_PIL_LSB +: PIL_W];
         if (state == s_enter_priv)
            privileged <= 1'b1;
         else if (wr_ctrl)
            privileged <= pwdata[CTRL_PRIV_BIT];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence frame_words;
      (state == s_push_pc) && frame_push_valid;
   endsequence

   sequence priv_then_table;
      privileged && (state == s_read_table) && table_read_req;
   endsequence

   chk_ie_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      take |=> !ie)
      else $error("enable flag not cleared by trap");
   chk_nmi_gate_ie: assert property (@(posedge pclk) disable iff (!presetn)
      inject_nmi |-> (ie && nmi_sync))
      else $error("nonmaskable injected while disabled");
   chk_irq_threshold: assert property (@(posedge pclk) disable iff (!presetn)
      (inject_ok && !inject_nmi) |-> (ie && (irl_sync > processor_priority_threshold) && d_inject))
      else $error("maskable level taken at or below threshold");
   chk_nmi_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      inject_nmi |=> (!nmi_armed && !inject_nmi))
      else $error("nonmaskable line not blocked after acceptance");
   chk_nmi_over_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (inject_ok && nmi_ok) |=> (d_nmi && d_kind == KIND_NMI))
      else $error("maskable level beat nonmaskable request");
   chk_frame_order: assert property (@(posedge pclk) disable iff (!presetn)
      take |=> frame_words ##0 (!privileged || $stable(privileged)))
      else $error("trap did not start with the frame");
   chk_table_priv: assert property (@(posedge pclk) disable iff (!presetn)
      (state == s_enter_priv) |=> priv_then_table)
      else $error("table read before privileged mode");
   chk_push_next_pc: assert property (@(posedge pclk) disable iff (!presetn)
      (take && win_int) |=> (frame_push_data == $past(c_next_pc)))
      else $error("interrupt frame holds wrong pc");
   chk_exc_first: assert property (@(posedge pclk) disable iff (!presetn)
      (take && (|exc_req)) |=> (last_kind != KIND_NMI && !took_nmi))
      else $error("interrupt beat a same-cycle exception");
   chk_vector: assert property (@(posedge pclk) disable iff (!presetn)
      table_read_req |-> (table_read_addr == tbase + (32'(last_kind) << VEC_SHIFT)))
      else $error("wrong handler vector address");

endmodule : trap_and_interrupt_control
`default_nettype wire

// [src/trap_ctrl_pkg.sv]
// ----------------------------------------------------------------
// shared constants for the trap and interrupt control block
// ----------------------------------------------------------------
package trap_ctrl_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TBASE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_LAST = 8'h10;
   localparam logic [7:0] ADDR_SAVED_PC = 8'h14;

   // ----------------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------------
   localparam int CTRL_IE_BIT = 0;
   localparam int CTRL_PIL_LSB = 4;
   localparam int CTRL_PRIV_BIT = 8;
   localparam int PIL_W = 4;
   localparam int ST_TRAP_BIT = 0;
   localparam int ST_NMI_BIT = 1;
   localparam int ST_IRQ_BIT = 2;
   localparam int ST_W = 3;
   localparam int KIND_W = 8;
   localparam int VEC_SHIFT = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_IE = 1'b0;
   localparam logic [3:0] RST_PIL = 4'h0;
   localparam logic RST_PRIV = 1'b1;
   localparam logic [31:0] RST_TBASE = 32'h0000_0000;
   localparam logic [2:0] RST_MASK = 3'h0;

   // ----------------------------------------------------------------
   // trap kind codes
   // ----------------------------------------------------------------
   localparam logic [7:0] KIND_EXC_BASE = 8'h10;
   localparam logic [7:0] KIND_IRQ_BASE = 8'h30;
   localparam logic [7:0] KIND_NMI = 8'h40;

   typedef enum logic [2:0] {
      s_idle,
      s_push_pc,
      s_push_psr,
      s_enter_priv,
      s_read_table,
      s_branch
   } trap_state_t;

   // handler vector address: table base plus kind-scaled offset
   function automatic logic [31:0] vector_of(input logic [31:0] base,
                                             input logic [7:0] kind);
      return base + (32'(kind) << VEC_SHIFT);
   endfunction : vector_of

endpackage : trap_ctrl_pkg

// [src/level_sync3.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// three-flop synchroniser with agreement filter
// ----------------------------------------------------------------
module level_sync3 #(
   parameter int W = 1
) (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic [W-1:0] async_in, // pin level, any timing
   output logic [W-1:0] stable_out // filtered level on pclk
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // s1 feeds only s2; value accepted when s2 and s3 agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         stable_out <= '0;
      end
      else
      begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
         begin
            stable_out <= s3;
         end
      end
   end

   chk_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
      (stable_out != $past(stable_out)) |-> ($past(s2) == $past(s3)))
      else $error("synchroniser output moved without agreement");

endmodule : level_sync3
`default_nettype wire

// [src/trap_prio.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// fixed priority pick, index 0 highest
// ----------------------------------------------------------------
module trap_prio #(
   parameter int N = 9,
   parameter int IW = 4
) (
   input wire logic pclk, // core clock, checks only
   input wire logic presetn, // reset, checks only
   input wire logic [N-1:0] req, // same-cycle trap conditions
   output logic any, // some condition present
   output logic [IW-1:0] idx // index of the winner
);
   // scan downward so the lowest set index is left standing
   always_comb
   begin
      any = |req;
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            idx = IW'(i);
         end
      end
   end

   chk_prio_lowest: assert property (@(posedge pclk) disable iff (!presetn)
      any |-> (req[idx] && ((req & ((N'(1) << idx) - N'(1))) == '0)))
      else $error("priority pick is not the highest condition");

endmodule : trap_prio
`default_nettype wire

// [bench/trap_far_side.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// stack and trap table responder with programmable latency
// ----------------------------------------------------------------
module trap_far_side (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic [1:0] lat, // wait cycles before each answer
   input wire logic frame_push_valid, // frame word offered
   input wire logic table_read_req, // table read pending
   input wire logic [31:0] table_read_addr, // vector address
   output logic frame_push_ready, // word taken
   output logic table_read_ack, // table data valid
   output logic [31:0] table_read_data // handler location
);
   logic [1:0] cnt;
   logic [31:0] entry;

   // answer once the wait count is reached, both stack and table
   assign frame_push_ready = frame_push_valid && cnt == lat;
   assign table_read_ack = table_read_req && cnt == lat;
   assign entry = table_read_addr ^ 32'hffff_0000;
   // outside the ack cycle show the inverse, so stale data never matches
   assign table_read_data = table_read_ack ? entry : ~entry;

   // wait counter restarts after every answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt <= 2'h0;
      else if ((frame_push_valid || table_read_req) && cnt != lat)
         cnt <= cnt + 2'h1;
      else
         cnt <= 2'h0;
   end
endmodule : trap_far_side
`default_nettype wire

// [bench/trap_and_interrupt_control_test.sv]
`timescale 1ns/100ps
`default_nettype none
module trap_and_interrupt_control_test
   import trap_ctrl_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus, monitor and checks
   // ----------------------------------------------------------------
   localparam logic [31:0] TBASE = 32'h0000_1000;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, exc_req = 8'h00;
   logic [31:0] pwdata = 32'h0, c_pc = 32'h0000_2000, c_next_pc = 32'h0000_2004;
   logic nonmaskable_request = 1'h0, pipe_advance = 1'h1;
   logic [3:0] request_level_input = 4'h0;
   logic [1:0] lat = 2'h0;
   logic [31:0] prdata, frame_push_data, table_read_addr, table_read_data, branch_target;
   logic pready, pslverr, irq, d_inject, trap_busy, frame_push_valid, frame_push_ready;
   logic table_read_req, table_read_ack, branch_valid, privileged, push_priv, read_priv;
   logic [31:0] words [0:3];
   logic [31:0] seen_vec, seen_tgt, q;
   logic e;
   int failures = 0, n_compared = 0, n_br = 0, n_inj = 0, nw = 0;

   trap_and_interrupt_control #(.N_EXC(8)) trap_and_interrupt_control_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .nonmaskable_request(nonmaskable_request),
      .request_level_input(request_level_input), .pipe_advance(pipe_advance),
      .exc_req(exc_req), .c_pc(c_pc), .c_next_pc(c_next_pc), .d_inject(d_inject),
      .trap_busy(trap_busy), .frame_push_valid(frame_push_valid),
      .frame_push_data(frame_push_data), .frame_push_ready(frame_push_ready),
      .table_read_req(table_read_req), .table_read_addr(table_read_addr),
      .table_read_ack(table_read_ack), .table_read_data(table_read_data),
      .branch_valid(branch_valid), .branch_target(branch_target), .privileged(privileged));

   trap_far_side trap_far_side_inst (
      .pclk(pclk), .presetn(presetn), .lat(lat), .frame_push_valid(frame_push_valid),
      .table_read_req(table_read_req), .table_read_addr(table_read_addr),
      .frame_push_ready(frame_push_ready), .table_read_ack(table_read_ack),
      .table_read_data(table_read_data));

   initial
   begin
      forever #5 pclk = ~pclk;
   end

   // record frame words, vector, target and mode at each step
   always @(posedge pclk)
   begin
      if (frame_push_valid && frame_push_ready)
      begin
         words[nw % 4] <= frame_push_data;
         nw <= nw + 1;
         push_priv <= privileged;
      end
      if (table_read_req && table_read_ack)
      begin
         seen_vec <= table_read_addr;
         read_priv <= privileged;
      end
      if (branch_valid)
      begin
         seen_tgt <= branch_target;
         n_br <= n_br + 1;
      end
      if (d_inject)
         n_inj <= n_inj + 1;
   end

   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      if (n >= 20)
      begin
         failures++;
         stop_test();
      end
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'h0, a, 32'h0);
      chk(nm, exp, q);
   endtask : rd

   // no trap and no injection may happen for n cycles
   task automatic quiet(input int n);
      int b, k;
      b = n_br;
      k = n_inj;
      repeat (n) @(posedge pclk);
      chk("trap count", 32'(b), 32'(n_br));
      chk("inject count", 32'(k), 32'(n_inj));
   endtask : quiet

   // enable, raise the requests, then follow one whole trap
   task automatic take(input logic [31:0] ctrl, input logic [3:0] lvl, input logic nmi,
                       input logic [7:0] exc, input logic [7:0] kind, input logic [31:0] pc,
                       input logic [2:0] st);
      int b, k, i, w;
      logic [31:0] vec;
      b = n_br;
      k = n_inj;
      i = 0;
      w = nw;
      vec = TBASE + {21'h0, kind, 3'h0};
      apb(1'h1, ADDR_CTRL, ctrl);
      request_level_input <= lvl;
      nonmaskable_request <= nmi; // level held, no clock relation
      exc_req <= exc;
      @(posedge pclk);
      exc_req <= 8'h00;
      while (n_br == b && i < 300)
      begin
         i++;
         @(posedge pclk);
      end
      if (n_br == b)
      begin
         failures++;
         stop_test();
      end
      chk("busy after", 32'h0, {31'h0, trap_busy});
      if (lvl != 4'h0 || nmi)
         chk("injected", 32'h1, {31'h0, n_inj > k});
      chk("vector", vec, seen_vec);
      chk("target", vec ^ 32'hffff_0000, seen_tgt);
      chk("saved pc", pc, words[w % 4]);
      chk("saved state", ctrl, words[(w + 1) % 4]);
      chk("mode order", {30'h0, ctrl[8], 1'h1}, {30'h0, push_priv, read_priv});
      rd(ADDR_CTRL, ctrl & 32'hffff_fffe | 32'h100, "ctrl after");
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk("status", {29'h0, st | 3'h1}, q);
      chk("irq clear", 32'h0, {31'h0, irq});
      rd(ADDR_LAST, {24'h0, kind}, "kind");
      rd(ADDR_SAVED_PC, pc, "pc reg");
      request_level_input <= 4'h0; // serviced, source may drop
   endtask : take

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      rd(ADDR_CTRL, 32'h0000_0100, "ctrl reset");
      rd(ADDR_TBASE, 32'h0, "tbase reset");
      rd(ADDR_MASK, 32'h0, "mask reset");
      rd(ADDR_STATUS, 32'h0, "status reset");
      apb(1'h0, 8'h18, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      apb(1'h1, ADDR_TBASE, TBASE);
      apb(1'h1, ADDR_MASK, 32'h7);
      rd(ADDR_MASK, 32'h7, "mask");
      take(32'h001, 4'h0, 1'h0, 8'h06, 8'h11, c_pc, 3'h1);
      lat <= 2'h3;
      request_level_input <= 4'h5;
      apb(1'h1, ADDR_CTRL, 32'h051);
      quiet(40); // level equal to threshold refused
      take(32'h051, 4'h6, 1'h0, 8'h00, 8'h36, c_next_pc, 3'h4);
      take(32'h151, 4'h6, 1'h0, 8'h00, 8'h36, c_next_pc, 3'h4);
      lat <= 2'h1;
      nonmaskable_request <= 1'h1;
      request_level_input <= 4'hf;
      apb(1'h1, ADDR_CTRL, 32'h0f0);
      quiet(40); // enable clear blocks both
      take(32'h0f1, 4'h0, 1'h1, 8'h00, 8'h40, c_next_pc, 3'h2);
      nonmaskable_request <= 1'h0;
      repeat (8) @(posedge pclk);
      take(32'h001, 4'hf, 1'h1, 8'h00, 8'h40, c_next_pc, 3'h2);
      take(32'h001, 4'h0, 1'h1, 8'h00, 8'h40, c_next_pc, 3'h2);
      nonmaskable_request <= 1'h0;
      stop_test();
   end
endmodule : trap_and_interrupt_control_test
`default_nettype wire
